// File: core/qbu_pkg.sv
package qbu_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned HALF_W     = 16;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned REG_IDX_W  = 3;
  localparam int unsigned ALIGN_W    = 2;
  // op field layout of the 32-bit opcode
  localparam int unsigned OPC_OP_LSB   = 0;
  localparam int unsigned OPC_REV_BIT  = 4;
  localparam int unsigned OPC_SRCA_BIT = 5;
  localparam int unsigned OPC_SRCB_BIT = 6;
  localparam int unsigned OPC_DST0_LSB = 8;
  localparam int unsigned OPC_DST1_LSB = 12;
  localparam int unsigned OPC_PAR_BIT  = 15;
  localparam logic [15:0] OPC_TAG      = 16'hC7A5;
  localparam int unsigned OPC_TAG_LSB  = 16;
  localparam logic [15:0] SAT_MAX      = 16'hFFFF;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  localparam logic [39:0] ZERO_ACC     = 40'h00_0000_0000;
  typedef enum logic [1:0]
  {
    QBU_OP_NONE   = 2'b00,
    QBU_OP_UNPACK = 2'b01,
    QBU_OP_SAA    = 2'b10
  } qbu_op_e;
endpackage

// File: core/qbu_align.sv
`timescale 1ns/10ps
module qbu_align
  import qbu_pkg::*;
(
  input  wire logic [qbu_pkg::DATA_W-1:0]  lo_reg_i,
  input  wire logic [qbu_pkg::DATA_W-1:0]  hi_reg_i,
  input  wire logic                        rev_i,
  input  wire logic [qbu_pkg::ALIGN_W-1:0] align_i,
  output logic      [qbu_pkg::DATA_W-1:0]  bytes_o
);
  import qbu_pkg::*;
  logic [63:0] window;
  always_comb
  begin
    if (rev_i)
      window = {lo_reg_i, hi_reg_i};
    else
      window = {hi_reg_i, lo_reg_i};
    bytes_o = window[{align_i, 3'b000} +: 32];
  end
endmodule

// File: core/qbu_unit.sv
// Behaviour
// - saa reverse option swaps pair's low source
// - forward: low bytes from low register
// - reverse: low bytes from high register
// - saa: four byte pairs, subtract-abs-accumulate
// - unpack copies four contiguous aligned bytes
// - first index low bits pick unpack alignment
// - codes 0..3 select byte3..0 through byte6..3
// - unpack reverse swaps registers, same alignment
// - bytes A,B to dest0; C,D to dest1
// - unpack destinations any of eight registers
// - suppress misaligned exceptions during unpack
// - unpack decoded as 32-bit opcode
// - allow parallel issue with 16-bit instructions
// - accumulator halves saturate, never wrap
// - second index aligns second source pair
`timescale 1ns/10ps
module qbu_unit
  import qbu_pkg::*;
(
  input  wire logic                          mclk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          issue_i,
  input  wire logic [qbu_pkg::DATA_W-1:0]    opcode_i,
  input  wire logic [qbu_pkg::DATA_W-1:0]    reg_r0_i,
  input  wire logic [qbu_pkg::DATA_W-1:0]    reg_r1_i,
  input  wire logic [qbu_pkg::DATA_W-1:0]    reg_r2_i,
  input  wire logic [qbu_pkg::DATA_W-1:0]    reg_r3_i,
  input  wire logic [qbu_pkg::ALIGN_W-1:0]   align_index_first_i,
  input  wire logic [qbu_pkg::ALIGN_W-1:0]   align_index_second_i,
  input  wire logic [39:0]                   accumulator_zero_i,
  input  wire logic [39:0]                   accumulator_one_i,
  output logic                               wr_en_o,
  output logic      [qbu_pkg::REG_IDX_W-1:0] wr_idx0_o,
  output logic      [qbu_pkg::REG_IDX_W-1:0] wr_idx1_o,
  output logic      [qbu_pkg::DATA_W-1:0]    wr_data0_o,
  output logic      [qbu_pkg::DATA_W-1:0]    wr_data1_o,
  output logic                               acc_wr_o,
  output logic      [39:0]                   accumulator_zero_o,
  output logic      [39:0]                   accumulator_one_o,
  output logic                               misalign_suppress_o,
  output logic                               par_issue_ok_o
);
  import qbu_pkg::*;

  function automatic logic [HALF_W-1:0] sat_add(input logic [HALF_W-1:0] acc, input logic [BYTE_W-1:0] d);
    logic [HALF_W:0] s;
    s = {1'b0, acc} + {9'h000, d};
    sat_add = s[HALF_W] ? SAT_MAX : s[HALF_W-1:0];
  endfunction

  function automatic logic [BYTE_W-1:0] abs_diff(input logic [BYTE_W-1:0] a, input logic [BYTE_W-1:0] b);
    abs_diff = (a >= b) ? 8'(a - b) : 8'(b - a);
  endfunction

  logic                dec_ok;
  qbu_op_e             op;
  logic                rev;
  logic [DATA_W-1:0]   pa_lo, pa_hi, pb_lo, pb_hi;
  logic [DATA_W-1:0]   bytes_a, bytes_b;

  // 32-bit opcode decode with tag in upper half
  assign dec_ok = issue_i && (opcode_i[OPC_TAG_LSB +: 16] == OPC_TAG);
  always_comb
  begin
    op = QBU_OP_NONE;
    if (dec_ok)
    begin
      case (opcode_i[OPC_OP_LSB +: 2])
        2'b01:   op = QBU_OP_UNPACK;
        2'b10:   op = QBU_OP_SAA;
        default: op = QBU_OP_NONE;
      endcase
    end
  end
  assign rev = opcode_i[OPC_REV_BIT];

  // pair select: only R1:0 / R3:2 are encodable
  assign pa_lo = opcode_i[OPC_SRCA_BIT] ? reg_r2_i : reg_r0_i;
  assign pa_hi = opcode_i[OPC_SRCA_BIT] ? reg_r3_i : reg_r1_i;
  assign pb_lo = opcode_i[OPC_SRCB_BIT] ? reg_r2_i : reg_r0_i;
  assign pb_hi = opcode_i[OPC_SRCB_BIT] ? reg_r3_i : reg_r1_i;

  qbu_align u_align_a
  (
    .lo_reg_i (pa_lo),
    .hi_reg_i (pa_hi),
    .rev_i    (rev),
    .align_i  (align_index_first_i),
    .bytes_o  (bytes_a)
  );

  qbu_align u_align_b
  (
    .lo_reg_i (pb_lo),
    .hi_reg_i (pb_hi),
    .rev_i    (rev),
    .align_i  (align_index_second_i),
    .bytes_o  (bytes_b)
  );

  logic                 wr_en_r, wr_en_nxt;
  logic [REG_IDX_W-1:0] wr_idx0_r, wr_idx0_nxt, wr_idx1_r, wr_idx1_nxt;
  logic [DATA_W-1:0]    wr_data0_r, wr_data0_nxt, wr_data1_r, wr_data1_nxt;
  logic                 acc_wr_r, acc_wr_nxt;
  logic [39:0]          acc0_r, acc0_nxt, acc1_r, acc1_nxt;
  logic [HALF_W-1:0]    h0, h1, h2, h3;

  always_comb
  begin
    wr_en_nxt    = 1'b0;
    wr_idx0_nxt  = wr_idx0_r;
    wr_idx1_nxt  = wr_idx1_r;
    wr_data0_nxt = wr_data0_r;
    wr_data1_nxt = wr_data1_r;
    acc_wr_nxt   = 1'b0;
    acc0_nxt     = acc0_r;
    acc1_nxt     = acc1_r;
    h0 = accumulator_zero_i[15:0];
    h1 = accumulator_zero_i[31:16];
    h2 = accumulator_one_i[15:0];
    h3 = accumulator_one_i[31:16];
    case (op)
      QBU_OP_UNPACK:
      begin
        wr_en_nxt    = 1'b1;
        wr_idx0_nxt  = opcode_i[OPC_DST0_LSB +: REG_IDX_W];
        wr_idx1_nxt  = opcode_i[OPC_DST1_LSB +: REG_IDX_W];
        // zero-extended halves
        wr_data0_nxt = {8'h00, bytes_a[15:8], 8'h00, bytes_a[7:0]};
        wr_data1_nxt = {8'h00, bytes_a[31:24], 8'h00, bytes_a[23:16]};
      end
      QBU_OP_SAA:
      begin
        // four lanes in parallel
        acc_wr_nxt = 1'b1;
        h0 = sat_add(h0, abs_diff(bytes_a[7:0], bytes_b[7:0]));
        h1 = sat_add(h1, abs_diff(bytes_a[15:8], bytes_b[15:8]));
        h2 = sat_add(h2, abs_diff(bytes_a[23:16], bytes_b[23:16]));
        h3 = sat_add(h3, abs_diff(bytes_a[31:24], bytes_b[31:24]));
        acc0_nxt = {accumulator_zero_i[39:32], h1, h0};
        acc1_nxt = {accumulator_one_i[39:32], h3, h2};
      end
      default:
      begin
        wr_en_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      wr_en_r    <= 1'b0;
      wr_idx0_r  <= 3'h0;
      wr_idx1_r  <= 3'h0;
      wr_data0_r <= ZERO_WORD;
      wr_data1_r <= ZERO_WORD;
      acc_wr_r   <= 1'b0;
      acc0_r     <= ZERO_ACC;
      acc1_r     <= ZERO_ACC;
    end
    else
    begin
      wr_en_r    <= wr_en_nxt;
      wr_idx0_r  <= wr_idx0_nxt;
      wr_idx1_r  <= wr_idx1_nxt;
      wr_data0_r <= wr_data0_nxt;
      wr_data1_r <= wr_data1_nxt;
      acc_wr_r   <= acc_wr_nxt;
      acc0_r     <= acc0_nxt;
      acc1_r     <= acc1_nxt;
    end
  end

  assign wr_en_o             = wr_en_r;
  assign wr_idx0_o           = wr_idx0_r;
  assign wr_idx1_o           = wr_idx1_r;
  assign wr_data0_o          = wr_data0_r;
  assign wr_data1_o          = wr_data1_r;
  assign acc_wr_o            = acc_wr_r;
  assign accumulator_zero_o  = acc0_r;
  assign accumulator_one_o   = acc1_r;
  assign misalign_suppress_o = (op == QBU_OP_UNPACK);
  assign par_issue_ok_o      = (op != QBU_OP_NONE) && opcode_i[OPC_PAR_BIT];

  unpack_wr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (op == QBU_OP_UNPACK) |=> wr_en_o && wr_data0_o[7:0] == $past(bytes_a[7:0])
                              && wr_data1_o[23:16] == $past(bytes_a[31:24]))
    else $error("unpack byte placement wrong");
  unpack_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_en_o |-> wr_data0_o[15:8] == 8'h00 && wr_data0_o[31:24] == 8'h00
                && wr_data1_o[15:8] == 8'h00 && wr_data1_o[31:24] == 8'h00)
    else $error("unpack upper bytes not zero");
  unpack_dest_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (op == QBU_OP_UNPACK) |=> wr_idx1_o == $past(opcode_i[14:12]) && wr_idx0_o == $past(opcode_i[10:8]))
    else $error("unpack destination index wrong");
  align_fwd_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!rev && align_index_first_i == 2'b00) |-> bytes_a == pa_lo)
    else $error("forward alignment zero wrong");
  align_rev_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rev && align_index_first_i == 2'b00) |-> bytes_a == pa_hi)
    else $error("reverse alignment zero wrong");
  align_three_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!rev && align_index_first_i == 2'b11) |-> bytes_a == {pa_hi[23:0], pa_lo[31:24]})
    else $error("alignment three wrong");
  saa_sat_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (op == QBU_OP_SAA) |=> accumulator_one_o[15:0] >= $past(accumulator_one_i[15:0])
                           && accumulator_zero_o[31:16] >= $past(accumulator_zero_i[31:16]))
    else $error("accumulator half wrapped");
  saa_lane_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (op == QBU_OP_SAA && bytes_a[23:16] == bytes_b[23:16])
    |=> acc_wr_o && accumulator_one_o[15:0] == $past(accumulator_one_i[15:0]))
    else $error("equal bytes changed accumulator");
  suppress_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    misalign_suppress_o == (issue_i && opcode_i[OPC_TAG_LSB +: 16] == OPC_TAG && opcode_i[1:0] == 2'b01))
    else $error("misalign suppress wrong");

  unpack_rev_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i) op == QBU_OP_UNPACK && rev);
  saa_fwd_c:    cover property (@(posedge mclk_i) disable iff (sys_rst_i) op == QBU_OP_SAA && !rev);
  saa_rev_c:    cover property (@(posedge mclk_i) disable iff (sys_rst_i) op == QBU_OP_SAA && rev);
  saa_sat_c:    cover property (@(posedge mclk_i) disable iff (sys_rst_i) acc_wr_o && accumulator_one_o[15:0] == SAT_MAX);
endmodule

// File: dv/qbu_rf_model.sv
`timescale 1ns/10ps
module qbu_rf_model
  import qbu_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        ld_i,
  input  wire logic [3:0]  ld_idx_i,
  input  wire logic [39:0] ld_val_i,
  input  wire logic        wr_en_i,
  input  wire logic [2:0]  idx0_i,
  input  wire logic [2:0]  idx1_i,
  input  wire logic [31:0] d0_i,
  input  wire logic [31:0] d1_i,
  input  wire logic        acc_wr_i,
  input  wire logic [39:0] acc0_i,
  input  wire logic [39:0] acc1_i,
  output logic      [9:0][39:0] rf_o
);
  // entries 0..7 data registers, 8 and 9 accumulators
  initial
  begin
    for (int i = 0; i < 10; i++)
      rf_o[i] = 40'h00_0000_0000;
  end
  always @(posedge mclk_i)
  begin
    if (ld_i)
      rf_o[ld_idx_i] <= ld_val_i;
    if (wr_en_i)
    begin
      rf_o[idx0_i] <= {8'h00, d0_i};
      rf_o[idx1_i] <= {8'h00, d1_i};
    end
    if (acc_wr_i)
    begin
      rf_o[8] <= acc0_i;
      rf_o[9] <= acc1_i;
    end
  end
endmodule

// File: dv/quad_byte_align_unpack_unit_test.sv
`timescale 1ns/10ps
module quad_byte_align_unpack_unit_test;
  import qbu_pkg::*;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        issue_i = 1'b0;
  logic [31:0] opcode_i = 32'h0000_0000;
  logic [1:0]  ai0 = 2'h0;
  logic [1:0]  ai1 = 2'h0;
  logic        ld = 1'b0;
  logic [3:0]  ld_idx = 4'h0;
  logic [39:0] ld_val = 40'h00_0000_0000;
  logic [9:0][39:0] rf;
  logic        wr_en, acc_wr, msup, par_ok;
  logic [2:0]  wi0, wi1;
  logic [31:0] wd0, wd1;
  logic [39:0] ao0, ao1;
  logic [31:0] sh [0:3];
  int          bad_count = 0;
  int          comparisons = 0;
  always #5 mclk_i = ~mclk_i;
  qbu_unit DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .issue_i(issue_i), .opcode_i(opcode_i),
    .reg_r0_i(rf[0][31:0]), .reg_r1_i(rf[1][31:0]), .reg_r2_i(rf[2][31:0]), .reg_r3_i(rf[3][31:0]),
    .align_index_first_i(ai0), .align_index_second_i(ai1), .accumulator_zero_i(rf[8]),
    .accumulator_one_i(rf[9]), .wr_en_o(wr_en), .wr_idx0_o(wi0), .wr_idx1_o(wi1), .wr_data0_o(wd0),
    .wr_data1_o(wd1), .acc_wr_o(acc_wr), .accumulator_zero_o(ao0), .accumulator_one_o(ao1),
    .misalign_suppress_o(msup), .par_issue_ok_o(par_ok));
  qbu_rf_model partner (.mclk_i(mclk_i), .ld_i(ld), .ld_idx_i(ld_idx), .ld_val_i(ld_val),
    .wr_en_i(wr_en), .idx0_i(wi0), .idx1_i(wi1), .d0_i(wd0), .d1_i(wd1), .acc_wr_i(acc_wr),
    .acc0_i(ao0), .acc1_i(ao1), .rf_o(rf));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic load(input logic [3:0] i, input logic [39:0] v);
    @(posedge mclk_i);
    ld <= 1'b1;
    ld_idx <= i;
    ld_val <= v;
    if (i < 4)
      sh[i[1:0]] = v[31:0];
    @(posedge mclk_i);
    ld <= 1'b0;
  endtask
  function automatic logic [31:0] opc(input logic [1:0] op, input logic rev, pa, pb,
                                      input logic [2:0] d0, d1, input logic par);
    return {OPC_TAG, par, d1, 1'b0, d0, 1'b0, pb, pa, rev, 2'b00, op};
  endfunction
  // aligned word from pair p: forward {hi,lo}, reverse {lo,hi}
  function automatic logic [31:0] sel(input logic p, rev, input logic [1:0] al);
    logic [63:0] w;
    w = rev ? {sh[2*p], sh[2*p+1]} : {sh[2*p+1], sh[2*p]};
    return w[al*8 +: 32];
  endfunction
  // expected words for R1:0 as loaded, half-word pair taken from start byte k
  function automatic logic [31:0] known(input logic rev, input logic [2:0] k);
    case ({rev, k})
      4'h0:    known = 32'h00BA_00DD;
      4'h1:    known = 32'h00EF_00BA;
      4'h2:    known = 32'h00BE_00EF;
      4'h3:    known = 32'h00CE_00BE;
      4'h4:    known = 32'h00FA_00CE;
      4'h5:    known = 32'h00ED_00FA;
      4'h8:    known = 32'h00FA_00CE;
      4'h9:    known = 32'h00ED_00FA;
      4'hA:    known = 32'h00FE_00ED;
      4'hB:    known = 32'h00DD_00FE;
      4'hC:    known = 32'h00BA_00DD;
      4'hD:    known = 32'h00EF_00BA;
      default: known = 32'h0000_0000;
    endcase
  endfunction
  // one op issued, result looked at in its single answer cycle
  task automatic issue(input logic [31:0] op, input logic [1:0] al0, al1);
    logic v;
    v = op[31:16] == OPC_TAG && (op[1:0] == 2'b01 || op[1:0] == 2'b10);
    @(posedge mclk_i);
    issue_i <= 1'b1;
    opcode_i <= op;
    ai0 <= al0;
    ai1 <= al1;
    #1;
    chk(msup, v && op[1:0] == 2'b01);
    chk(par_ok, v && op[15]);
    @(posedge mclk_i);
    issue_i <= 1'b0;
    #1;
    chk(wr_en, v && op[1:0] == 2'b01);
    chk(acc_wr, v && op[1:0] == 2'b10);
  endtask
  task automatic unpack_case(input logic rev, p, input logic [1:0] al, input logic [2:0] d0, d1);
    logic [31:0] b;
    b = sel(p, rev, al);
    issue(opc(2'b01, rev, p, 1'b0, d0, d1, 1'b0), al, ~al);
    chk(wi0, d0);
    chk(wi1, d1);
    chk(wd0, {8'h00, b[15:8], 8'h00, b[7:0]});
    chk(wd1, {8'h00, b[31:24], 8'h00, b[23:16]});
    if (!p)
    begin
      chk(wd0, known(rev, {1'b0, al}));
      chk(wd1, known(rev, {1'b0, al} + 3'd2));
    end
  endtask
  task automatic saa_case(input logic rev, pb, input logic [1:0] al0, al1);
    logic [31:0] x, y;
    logic [15:0] h [0:3];
    logic [16:0] s;
    x = sel(1'b0, rev, al0);
    y = sel(pb, rev, al1);
    issue(opc(2'b10, rev, 1'b0, pb, 3'h0, 3'h0, 1'b1), al0, al1);
    for (int i = 0; i < 4; i++)
    begin
      s = rf[8 + i/2][16*(i%2) +: 16] + (x[8*i +: 8] > y[8*i +: 8] ? x[8*i +: 8] - y[8*i +: 8]
                                                                  : y[8*i +: 8] - x[8*i +: 8]);
      h[i] = s[16] ? SAT_MAX : s[15:0];
    end
    chk(ao0, {rf[8][39:32], h[1], h[0]});
    chk(ao1, {rf[9][39:32], h[3], h[2]});
  endtask
  task automatic reset_case();
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(wr_en, 1'b0);
    chk(acc_wr, 1'b0);
    chk(wd0, 32'h0000_0000);
    chk(ao1, 40'h00_0000_0000);
  endtask
  // bad op code and bad tag are both ignored, destinations keep the last unpack
  task automatic refused_case();
    issue(opc(2'b11, 1'b0, 1'b0, 1'b1, 3'h4, 3'h5, 1'b1), 2'b00, 2'b00);
    issue(opc(2'b01, 1'b0, 1'b0, 1'b1, 3'h4, 3'h5, 1'b1) ^ 32'h0001_0000, 2'b00, 2'b00);
    chk(wi0, 3'h6);
  endtask
  initial
  begin
    #100000;
    bad_count++;
    conclude();
  end
  initial
  begin
    reset_case();
    load(4'h0, 40'h00_BEEF_BADD);
    load(4'h1, 40'h00_FEED_FACE);
    load(4'h2, 40'h00_1122_3344);
    load(4'h3, 40'h00_A0B0_C0D0);
    load(4'h8, 40'h12_FFF0_0005);
    load(4'h9, 40'h00_0100_FFFE);
    for (int r = 0; r < 2; r++)
      for (int a = 0; a < 4; a++)
        unpack_case(r[0], 1'b0, a[1:0], 3'(4 + a), 3'(7 - a));
    unpack_case(1'b1, 1'b1, 2'b10, 3'h6, 3'h5);
    refused_case();
    saa_case(1'b0, 1'b1, 2'b01, 2'b11);
    saa_case(1'b1, 1'b1, 2'b10, 2'b00);
    saa_case(1'b0, 1'b1, 2'b00, 2'b10);
    saa_case(1'b1, 1'b1, 2'b11, 2'b01);
    saa_case(1'b0, 1'b0, 2'b01, 2'b01);
    conclude();
  end
endmodule
